// *** hw/ccrb_pkg.sv ***
// constants and types shared by the codec control register bank
package ccrb_pkg;

  localparam int DATA_W   = 16;
  localparam int NUM_REGS = 9;
  localparam int IO_W     = 10;
  localparam int ADDR_W   = 4;

  // register addresses
  localparam logic [3:0] ADDR_PIN_LEVEL  = 4'h0;
  localparam logic [3:0] ADDR_PIN_DIR    = 4'h1;
  localparam logic [3:0] ADDR_RISE_EN    = 4'h2;
  localparam logic [3:0] ADDR_FALL_EN    = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
  localparam logic [3:0] ADDR_PHONE_A    = 4'h5;
  localparam logic [3:0] ADDR_PHONE_B    = 4'h6;
  localparam logic [3:0] ADDR_VOICE_A    = 4'h7;
  localparam logic [3:0] ADDR_VOICE_B    = 4'h8;

  // reset values
  localparam logic [15:0] RST_ZERO    = 16'h0000;
  localparam logic [15:0] RST_PHONE_A = 16'h0010;
  localparam logic [15:0] RST_VOICE_A = 16'h0006;

  // writable bits per register, other bits read zero except the telecom clip flag
  localparam logic [15:0] WMASK_PIN_LEVEL = 16'h03FF;
  localparam logic [15:0] WMASK_PIN_DIR   = 16'h83FF;
  localparam logic [15:0] WMASK_IRQ       = 16'hFBFF;
  localparam logic [15:0] WMASK_PHONE_A   = 16'h00FF;
  localparam logic [15:0] WMASK_PHONE_B   = 16'hE848;
  localparam logic [15:0] WMASK_VOICE_A   = 16'h0FFF;
  localparam logic [15:0] WMASK_VOICE_B   = 16'hE15F;

  // field positions
  localparam int BIT_SIB_ZERO     = 15;
  localparam int BIT_TEL_LOOP     = 7;
  localparam int BIT_HIGH_PASS    = 3;
  localparam int BIT_TEL_CLIP     = 4;
  localparam int BIT_TEL_ATT      = 6;
  localparam int BIT_SIDE_SUP     = 11;
  localparam int BIT_MUTE         = 13;
  localparam int BIT_PATH_IN      = 14;
  localparam int BIT_PATH_OUT     = 15;
  localparam int BIT_AUD_CLIP_ENA = 6;
  localparam int BIT_AUD_LOOP     = 8;
  localparam int DIV_LSB          = 0;
  localparam int DIV_W            = 7;
  localparam int GAIN_LSB         = 7;
  localparam int LEVEL_W          = 5;
  localparam int ATT_LSB          = 0;
  localparam int IRQ_ADC          = 11;
  localparam int IRQ_TSPX         = 12;
  localparam int IRQ_TSMX         = 13;
  localparam int IRQ_TCLIP        = 14;
  localparam int IRQ_ACLIP        = 15;

  // frame bit indices, counted from the bit sampled with sync high
  localparam logic [7:0] FRAME_BIT_WRITE  = 8'h10;
  localparam logic [7:0] FRAME_ADDR_FIRST = 8'h11;
  localparam logic [7:0] FRAME_ADDR_LAST  = 8'h14;
  localparam logic [7:0] FRAME_DATA_FIRST = 8'h20;
  localparam logic [7:0] FRAME_DATA_LAST  = 8'h2F;
  localparam logic [7:0] FRAME_COMMIT_BIT = 8'h40;
  localparam logic [7:0] FRAME_LAST_BIT   = 8'h7F;

  typedef enum logic {FR_IDLE, FR_BUSY} ccrb_frame_t;

endpackage

// *** hw/ccrb_irq_if.sv ***
// interrupt capture connection between the register bank and its capture block
`timescale 1ns/10ps
interface ccrb_irq_if;
  logic [15:0] source;
  logic [15:0] riseEna;
  logic [15:0] fallEna;
  logic [15:0] clear;
  logic [15:0] status;
  modport capture (input source, input riseEna, input fallEna, input clear, output status);
  modport control (output source, output riseEna, output fallEna, output clear, input status);
endinterface

// *** hw/ccrb_sync.sv ***
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module ccrb_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinSync
);
  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } ccrb_sync_t;

  ccrb_sync_t state, next_state;

  always_comb begin
    next_state.stage1 = pinIn;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pinSync = state.stage2;
endmodule

// *** hw/ccrb_irq.sv ***
// edge interrupt capture with sticky status, runs on the system clock
`timescale 1ns/10ps
module ccrb_irq
  import ccrb_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  ccrb_irq_if.capture bus
);
  typedef struct packed {
    logic [15:0] prevSrc;
    logic [15:0] status;
  } ccrb_irq_t;

  ccrb_irq_t state, next_state;
  logic [15:0] edges;

  always_comb begin
    edges = (bus.source & ~state.prevSrc & bus.riseEna)
          | (~bus.source & state.prevSrc & bus.fallEna);
    next_state.prevSrc = bus.source;
    // a new edge in the clear cycle survives the clear
    next_state.status = ((state.status & ~bus.clear) | edges) & WMASK_IRQ;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign bus.status = state.status;
endmodule

// *** hw/ccrb_bank.sv ***
// codec control register bank behind the four-wire serial frame port
`timescale 1ns/10ps

// Operation
// - stored pin data drives output pins
// - pin data read returns sampled pin levels
// - direction bit one means output
// - bit 15 drives dout low in word two
// - rise enables arm rising edge interrupts
// - fall enables arm falling edge interrupts
// - status read returns latched interrupt flags
// - zero-to-one write clears interrupt flag
// - telecom divisor resets to 16, range 16-127
// - telecom loopback control bit
// - voice band filter enable bit
// - latched clip flag, cleared by rising write
// - telecom input 6dB attenuation enable
// - sidetone, mute and path enables telecom
// - audio divisor resets to 6, range 6-127
// - audio input gain five-bit field
// - audio output attenuation five-bit field
// - audio clip detection enable
// - audio loopback control bit
// - audio mute and path enables
// - write only with flag, at bit 64
// - returned data sampled before frame start
// - interrupt pin is OR of status
// - capture runs without serial clock
module ccrb_bank
  import ccrb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        sibClk,
  input  wire logic        sibSync,
  input  wire logic        sibDin,
  output logic             sibDout,
  output logic             sibDoutEnN,
  input  wire logic [9:0]  ioIn,
  output logic      [9:0]  ioOut,
  output logic      [9:0]  ioOutEnN,
  input  wire logic        adcReady,
  input  wire logic        tspxLow,
  input  wire logic        tsmxLow,
  input  wire logic        telClipDetect,
  input  wire logic        audClipDetect,
  output logic             irqOut,
  output logic      [6:0]  telDiv,
  output logic             telLoopEna,
  output logic             telHighPassEna,
  output logic             telAttEna,
  output logic             sideSupEna,
  output logic             telMute,
  output logic             telInEna,
  output logic             telOutEna,
  output logic      [6:0]  audDiv,
  output logic      [4:0]  audGain,
  output logic      [4:0]  audAtt,
  output logic             audClipEna,
  output logic             audLoopEna,
  output logic             audMute,
  output logic             audInEna,
  output logic             audOutEna
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    ccrb_frame_t             frame;
    logic [7:0]              bitIdx;
    logic                    sclkPrev;
    logic                    wrFlag;
    logic [3:0]              addr;
    logic [15:0]             wdata;
    logic                    lastDin;
    logic [NUM_REGS-1:0][15:0] regs;
    logic [NUM_REGS-1:0][15:0] snap;
    logic [15:0]             lastClrIrq;
    logic                    lastClrTel;
    logic                    telClip;
    logic [15:0]             irqClear;
    logic                    sibDout;
    logic                    sibDoutEnN;
    logic [9:0]              ioOutEnN;
    logic                    irqOut;
  } ccrb_bank_t;

  ccrb_bank_t state, next_state;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and interrupt capture

  logic [17:0] pinSync;
  logic        sclk;
  logic        syncIn;
  logic        din;
  logic [9:0]  ioLevel;
  logic        adcSync;
  logic        tspxSync;
  logic        tsmxSync;
  logic        telDetSync;
  logic        audDetSync;

  ccrb_sync #(.W(18)) u_sync (
    .clk     (clk),
    .resetn  (resetn),
    .pinIn   ({sibClk, sibSync, sibDin, ioIn, adcReady, tspxLow, tsmxLow,
               telClipDetect, audClipDetect}),
    .pinSync (pinSync)
  );

  assign {sclk, syncIn, din, ioLevel, adcSync, tspxSync, tsmxSync,
          telDetSync, audDetSync} = pinSync;

  ccrb_irq_if irqBus ();

  // audio clip detector output only counts while audio clip detection is on
  assign irqBus.source  = {audDetSync & state.regs[ADDR_VOICE_B][BIT_AUD_CLIP_ENA],
                           state.telClip, tsmxSync, tspxSync, adcSync, 1'b0, ioLevel};
  assign irqBus.riseEna = state.regs[ADDR_RISE_EN];
  assign irqBus.fallEna = state.regs[ADDR_FALL_EN];
  assign irqBus.clear   = state.irqClear;

  // capture is clocked by clk, so edges latch with the frame clock stopped
  ccrb_irq u_irq (
    .clk    (clk),
    .resetn (resetn),
    .bus    (irqBus.capture)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [15:0] wmask(input logic [3:0] a);
    case (a)
      ADDR_PIN_LEVEL: wmask = WMASK_PIN_LEVEL;
      ADDR_PIN_DIR:   wmask = WMASK_PIN_DIR;
      ADDR_RISE_EN:   wmask = WMASK_IRQ;
      ADDR_FALL_EN:   wmask = WMASK_IRQ;
      ADDR_PHONE_A:   wmask = WMASK_PHONE_A;
      ADDR_PHONE_B:   wmask = WMASK_PHONE_B;
      ADDR_VOICE_A:   wmask = WMASK_VOICE_A;
      ADDR_VOICE_B:   wmask = WMASK_VOICE_B;
      default:        wmask = RST_ZERO;
    endcase
  endfunction

  function automatic logic [15:0] readWord(input logic [3:0] a,
                                           input logic [15:0] stored,
                                           input logic [9:0] pins,
                                           input logic [15:0] irqStat,
                                           input logic clipFlag);
    case (a)
      ADDR_PIN_LEVEL:  readWord = {6'h00, pins};
      ADDR_IRQ_STATUS: readWord = irqStat;
      ADDR_PHONE_B:    readWord = stored | (16'(clipFlag) << BIT_TEL_CLIP);
      default:         readWord = stored;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // frame engine and register writes

  logic        fall;
  logic        rise;
  logic        inFrame;
  logic [7:0]  idx;
  logic        commit;
  logic        telClr;
  logic [15:0] selWord;
  logic [3:0]  dataPos;

  always_comb begin
    next_state = state;
    next_state.irqClear = 16'h0000;
    fall    = state.sclkPrev & ~sclk;
    rise    = ~state.sclkPrev & sclk;
    inFrame = state.frame == FR_BUSY;
    idx     = (fall && syncIn) ? 8'h00 : state.bitIdx;
    commit  = 1'b0;
    telClr  = 1'b0;
    selWord = (state.addr < 4'(NUM_REGS)) ? state.snap[state.addr] : RST_ZERO;
    dataPos = 4'(FRAME_DATA_LAST - state.bitIdx);
    next_state.sclkPrev = sclk;

    // input bits are taken on the falling edge of the frame clock
    if (fall && (syncIn || inFrame)) begin
      if (syncIn) begin
        next_state.frame  = FR_BUSY;
        next_state.wrFlag = 1'b0;
        // returned data is the content just before this frame
        for (int i = 0; i < NUM_REGS; i++) begin
          next_state.snap[i] = readWord(4'(i), state.regs[i], ioLevel,
                                        irqBus.status, state.telClip);
        end
      end
      next_state.lastDin = din;
      next_state.bitIdx  = idx + 8'h01;
      if (idx == FRAME_BIT_WRITE) begin
        next_state.wrFlag = din;
      end
      if (idx >= FRAME_ADDR_FIRST && idx <= FRAME_ADDR_LAST) begin
        next_state.addr = {state.addr[2:0], din};
      end
      if (idx >= FRAME_DATA_FIRST && idx <= FRAME_DATA_LAST) begin
        next_state.wdata = {state.wdata[14:0], din};
      end
      commit = (idx == FRAME_COMMIT_BIT) && state.wrFlag;
      if (idx == FRAME_LAST_BIT) begin
        next_state.frame = FR_IDLE;
      end
    end

    if (commit) begin
      case (state.addr)
        ADDR_IRQ_STATUS: begin
          next_state.irqClear   = state.wdata & ~state.lastClrIrq & WMASK_IRQ;
          next_state.lastClrIrq = state.wdata;
        end
        ADDR_PHONE_B: begin
          next_state.regs[ADDR_PHONE_B] = state.wdata & WMASK_PHONE_B;
          telClr = state.wdata[BIT_TEL_CLIP] & ~state.lastClrTel;
          next_state.lastClrTel = state.wdata[BIT_TEL_CLIP];
        end
        default: begin
          if (state.addr < 4'(NUM_REGS)) begin
            next_state.regs[state.addr] = state.wdata & wmask(state.addr);
          end
        end
      endcase
    end

    // clip flag latches the detector until cleared; a detection in the clear cycle wins
    next_state.telClip = (state.telClip & ~telClr) | telDetSync;

    // output bits change on the rising edge ahead of the next sample
    if (rise) begin
      if (!inFrame) begin
        next_state.sibDout    = 1'b0;
        next_state.sibDoutEnN = 1'b1;
      end else if (state.bitIdx >= FRAME_COMMIT_BIT) begin
        next_state.sibDout    = 1'b0;
        next_state.sibDoutEnN = ~state.regs[ADDR_PIN_DIR][BIT_SIB_ZERO];
      end else begin
        next_state.sibDoutEnN = 1'b0;
        next_state.sibDout    = 1'b0;
        // address echo lags the incoming address by one bit
        if (state.bitIdx > FRAME_ADDR_FIRST && state.bitIdx <= FRAME_ADDR_LAST + 8'h01) begin
          next_state.sibDout = state.lastDin;
        end
        if (state.bitIdx >= FRAME_DATA_FIRST && state.bitIdx <= FRAME_DATA_LAST) begin
          next_state.sibDout = selWord[dataPos];
        end
      end
    end

    next_state.ioOutEnN = ~next_state.regs[ADDR_PIN_DIR][9:0];
    next_state.irqOut   = |irqBus.status;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state            <= '0;
      state.frame      <= FR_IDLE;
      state.regs[ADDR_PHONE_A] <= RST_PHONE_A;
      state.regs[ADDR_VOICE_A] <= RST_VOICE_A;
      state.sibDoutEnN <= 1'b1;
      state.ioOutEnN   <= 10'h3FF;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all taken from flip-flops

  assign sibDout    = state.sibDout;
  assign sibDoutEnN = state.sibDoutEnN;
  assign ioOut      = state.regs[ADDR_PIN_LEVEL][9:0];
  assign ioOutEnN   = state.ioOutEnN;
  assign irqOut     = state.irqOut;

  assign telDiv         = state.regs[ADDR_PHONE_A][DIV_LSB +: DIV_W];
  assign telLoopEna     = state.regs[ADDR_PHONE_A][BIT_TEL_LOOP];
  assign telHighPassEna = state.regs[ADDR_PHONE_B][BIT_HIGH_PASS];
  assign telAttEna      = state.regs[ADDR_PHONE_B][BIT_TEL_ATT];
  assign sideSupEna     = state.regs[ADDR_PHONE_B][BIT_SIDE_SUP];
  assign telMute        = state.regs[ADDR_PHONE_B][BIT_MUTE];
  assign telInEna       = state.regs[ADDR_PHONE_B][BIT_PATH_IN];
  assign telOutEna      = state.regs[ADDR_PHONE_B][BIT_PATH_OUT];
  assign audDiv         = state.regs[ADDR_VOICE_A][DIV_LSB +: DIV_W];
  assign audGain        = state.regs[ADDR_VOICE_A][GAIN_LSB +: LEVEL_W];
  assign audAtt         = state.regs[ADDR_VOICE_B][ATT_LSB +: LEVEL_W];
  assign audClipEna     = state.regs[ADDR_VOICE_B][BIT_AUD_CLIP_ENA];
  assign audLoopEna     = state.regs[ADDR_VOICE_B][BIT_AUD_LOOP];
  assign audMute        = state.regs[ADDR_VOICE_B][BIT_MUTE];
  assign audInEna       = state.regs[ADDR_VOICE_B][BIT_PATH_IN];
  assign audOutEna      = state.regs[ADDR_VOICE_B][BIT_PATH_OUT];

endmodule

// *** verif/ccrb_chk.sv ***
// port checks for the codec control register bank
`timescale 1ns/10ps
module ccrb_chk (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       sibClk,
  input wire logic       sibDout,
  input wire logic       sibDoutEnN,
  input wire logic [9:0] ioIn,
  input wire logic [9:0] ioOut,
  input wire logic [9:0] ioOutEnN,
  input wire logic       adcReady,
  input wire logic       tspxLow,
  input wire logic       tsmxLow,
  input wire logic       telClipDetect,
  input wire logic       audClipDetect,
  input wire logic       irqOut,
  input wire logic [6:0] telDiv,
  input wire logic [6:0] audDiv,
  input wire logic [4:0] audGain,
  input wire logic [4:0] audAtt
);
  logic [3:0]  riseCnt, fallCnt, srcCnt;
  logic        clkPrev;
  logic [14:0] srcPrev;
  wire  [14:0] srcNow = {ioIn, adcReady, tspxLow, tsmxLow, telClipDetect, audClipDetect};
  // ages saturate so a stopped bit clock never wraps back into a legal window
  always_ff @(posedge clk) begin
    clkPrev <= sibClk;
    srcPrev <= srcNow;
    if (!resetn) begin
      riseCnt <= 4'hF;
      fallCnt <= 4'hF;
      srcCnt  <= 4'hF;
    end else begin
      riseCnt <= (sibClk && !clkPrev) ? 4'h0 : riseCnt + 4'(riseCnt != 4'hF);
      fallCnt <= (!sibClk && clkPrev) ? 4'h0 : fallCnt + 4'(fallCnt != 4'hF);
      srcCnt  <= (srcNow != srcPrev) ? 4'h0 : srcCnt + 4'(srcCnt != 4'hF);
    end
  end
  ////////////////////////////////////////////////////////////////
  chk_reset_values: assert property (@(posedge clk)
    !resetn |=> sibDoutEnN && ioOutEnN == 10'h3FF && !irqOut && telDiv == 7'h10 && audDiv == 7'h06)
    else $error("outputs not at reset values");
  chk_pin_commit: assert property (@(posedge clk) disable iff (!resetn)
    $changed(ioOut) |-> fallCnt inside {[1:7]})
    else $error("pin data changed away from a commit");
  chk_dir_commit: assert property (@(posedge clk) disable iff (!resetn)
    $changed(ioOutEnN) |-> fallCnt inside {[1:7]})
    else $error("pin direction changed away from a commit");
  chk_codec_commit: assert property (@(posedge clk) disable iff (!resetn)
    $changed({telDiv, audDiv, audGain, audAtt}) |-> fallCnt inside {[1:7]})
    else $error("codec field changed away from a commit");
  chk_dout_timing: assert property (@(posedge clk) disable iff (!resetn)
    $changed(sibDout) |-> riseCnt inside {[1:5]})
    else $error("serial output changed off a bit clock rise");
  chk_enable_timing: assert property (@(posedge clk) disable iff (!resetn)
    $changed(sibDoutEnN) |-> riseCnt inside {[1:5]})
    else $error("serial enable changed off a bit clock rise");
  chk_irq_cause: assert property (@(posedge clk) disable iff (!resetn)
    $rose(irqOut) |-> srcCnt inside {[1:6]})
    else $error("interrupt rose without a source edge");
  chk_irq_clear: assert property (@(posedge clk) disable iff (!resetn)
    $fell(irqOut) |-> fallCnt inside {[3:9]})
    else $error("interrupt fell away from a commit");
endmodule
bind ccrb_bank ccrb_chk u_chk (.*);

// *** verif/ccrb_host.sv ***
// system controller model that clocks serial frames into the bank
`timescale 1ns/10ps
module ccrb_host (
  input  wire logic clk,
  output logic      sibClk,
  output logic      sibSync,
  output logic      sibDin,
  input  wire logic sibDout,
  input  wire logic sibDoutEnN
);
  localparam int HALF = 5;
  initial begin
    sibClk = 1'b0;
    sibSync = 1'b0;
    sibDin = 1'b0;
  end
  // bit clock stands low between frames; one trailing rise releases the output
  task automatic frame(input logic wr, input logic [3:0] addr, input logic [15:0] wdata,
                       output logic [15:0] rdata, output logic en);
    logic [127:0] bits;
    bits = '0;
    bits[16] = wr;
    for (int i = 0; i < 4; i++) bits[17 + i] = addr[3 - i];
    for (int i = 0; i < 16; i++) bits[32 + i] = wdata[15 - i];
    for (int k = 0; k < 129; k++) begin
      @(posedge clk);
      sibClk <= 1'b1;
      sibSync <= (k == 0);
      sibDin <= (k < 128) ? bits[k] : ~sibDin;
      repeat (HALF) @(posedge clk);
      sibClk <= 1'b0;
      repeat (HALF - 1) @(posedge clk);
      if (k >= 32 && k < 48) rdata[47 - k] = sibDout;
      if (k == 100) en = sibDoutEnN;
    end
  endtask
endmodule

// *** verif/tb_codec_control_register_bank.sv ***
// self-checking bench for the codec control register bank
`timescale 1ns/10ps
module tb_codec_control_register_bank;
  import ccrb_pkg::*;
  logic        clk, resetn, sibClk, sibSync, sibDin, sibDout, sibDoutEnN, b;
  logic        adcReady, tspxLow, tsmxLow, telClipDetect, audClipDetect, irqOut;
  logic        telLoopEna, telHighPassEna, telAttEna, sideSupEna, telMute, telInEna;
  logic        telOutEna, audClipEna, audLoopEna, audMute, audInEna, audOutEna;
  logic [6:0]  telDiv, audDiv;
  logic [4:0]  audGain, audAtt;
  logic [9:0]  ioIn, ioOut, ioOutEnN, ext;
  logic [15:0] st [0:8];
  logic [15:0] irqExp, v, m;
  logic        clipExp;
  int          n_fail, n_checks, cycles, s;
  int          srcs [5] = '{4, 11, 12, 13, 15};
  wire  [35:0] fields = {telDiv, telLoopEna, telHighPassEna, telAttEna, sideSupEna, telMute,
                         telInEna, telOutEna, audDiv, audGain, audAtt, audClipEna, audLoopEna,
                         audMute, audInEna, audOutEna};
  // released pins float to the external level
  assign ioIn = (~ioOutEnN & ioOut) | (ioOutEnN & ext);
  ccrb_bank uut (.*);
  ccrb_host host (.*);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      n_fail++;
      $display("MISMATCH at %0t: cycle limit reached", $time);
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic [15:0] wmask(input int a);
    case (a)
      0: return WMASK_PIN_LEVEL;
      1: return WMASK_PIN_DIR;
      2, 3: return WMASK_IRQ;
      5: return WMASK_PHONE_A;
      6: return WMASK_PHONE_B;
      7: return WMASK_VOICE_A;
      8: return WMASK_VOICE_B;
      default: return 16'h0000;
    endcase
  endfunction
  function automatic logic [15:0] exp_read(input int a);
    if (a == 0) return {6'h00, (st[1][9:0] & st[0][9:0]) | (~st[1][9:0] & ext)};
    if (a == 4) return irqExp;
    if (a == 6) return (st[6] & wmask(6)) | {11'h000, clipExp, 4'h0};
    if (a > 8) return 16'h0000;
    return st[a] & wmask(a);
  endfunction
  function automatic logic [35:0] exp_out();
    return {st[5][6:0], st[5][7], st[6][3], st[6][6], st[6][11], st[6][13], st[6][14],
            st[6][15], st[7][6:0], st[7][11:7], st[8][4:0], st[8][6], st[8][8], st[8][13],
            st[8][14], st[8][15]};
  endfunction
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: %s got %b", $time, what, got);
    end
  endtask
  task automatic cmp_wide(input logic [35:0] got, input logic [35:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input int a, input logic [15:0] d);
    logic [15:0] e, q;
    logic        en;
    e = exp_read(a);
    host.frame(w, 4'(a), d, q, en);
    cmp_word(q, e, "frame data");
    if (!w) cmp_bit(en, ~st[1][15], "word two drive");
    if (w && a < 9 && a != 4) st[a] = d;
  endtask
  task automatic drive_src(input logic lvl);
    @(posedge clk);
    case (s)
      4: ext[4] <= lvl;
      11: adcReady <= lvl;
      12: tspxLow <= lvl;
      13: tsmxLow <= lvl;
      default: audClipDetect <= lvl;
    endcase
    repeat (8) @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    {adcReady, tspxLow, tsmxLow, telClipDetect, audClipDetect} = 5'h00;
    ext = 10'h000;
    clipExp = 1'b0;
    irqExp = 16'h0000;
    foreach (st[i]) st[i] = 16'h0000;
    st[5] = 16'h0010;
    st[7] = 16'h0006;
    void'($urandom(9251));
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    // first write to each place other than status returns its reset contents, except pin data which returns pin levels
    for (int a = 0; a < 10; a++) begin
      if (a == 4) continue;
      ext <= 10'($urandom);
      @(posedge clk);
      v = 16'($urandom);
      if (a == 5) v[6:0] = 7'(16 + $urandom % 112);
      if (a == 7) v[6:0] = 7'(6 + $urandom % 122);
      xfer(1'b1, a, v);
      xfer(1'b0, a, 16'($urandom));
    end
    cmp_wide(fields, exp_out(), "codec fields");
    cmp_wide({ioOut, ioOutEnN, 16'h0000}, {st[0][9:0], ~st[1][9:0], 16'h0000}, "pins");
    ext <= 10'h000;
    xfer(1'b1, 1, 16'h0000);
    xfer(1'b1, 8, 16'h0040);
    xfer(1'b1, 2, 16'h0000);
    xfer(1'b1, 3, 16'h0000);
    host.frame(1'b1, 4'h4, 16'h0000, v, b);
    host.frame(1'b1, 4'h4, 16'hFBFF, v, b);
    repeat (8) @(posedge clk);
    cmp_bit(irqOut, 1'b0, "irq idle");
    foreach (srcs[i]) begin
      s = srcs[i];
      m = 16'h0001 << s;
      xfer(1'b1, 2, m);
      xfer(1'b1, 3, m);
      drive_src(1'b1);
      cmp_bit(irqOut, 1'b1, "rise sets");
      irqExp = m;
      xfer(1'b1, 4, 16'h0000);
      xfer(1'b1, 4, m);
      irqExp = 16'h0000;
      cmp_bit(irqOut, 1'b0, "cleared");
      drive_src(1'b0);
      cmp_bit(irqOut, 1'b1, "fall sets");
      irqExp = m;
      xfer(1'b1, 4, m);
      xfer(1'b1, 4, 16'h0000);
      xfer(1'b1, 4, m);
      irqExp = 16'h0000;
      cmp_bit(irqOut, 1'b0, "cleared");
    end
    @(posedge clk);
    telClipDetect <= 1'b1;
    repeat (4) @(posedge clk);
    telClipDetect <= 1'b0;
    clipExp = 1'b1;
    xfer(1'b0, 6, 16'h0000);
    xfer(1'b1, 6, st[6] & 16'hFFEF);
    xfer(1'b1, 6, st[6] | 16'h0010);
    clipExp = 1'b0;
    xfer(1'b0, 6, 16'h0000);
    print_verdict();
  end
endmodule
